// ==== hw/pch_pkg.sv ====
// Constants for the function's configuration header register bank.
// Assumes an APB slave with 32-bit data and byte addresses.

package pch_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_CLASS    = 8'h08;
    localparam logic [7:0] ADDR_MISC     = 8'h0c;
    localparam logic [7:0] ADDR_IO_BASE  = 8'h10;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h14;
    localparam logic [7:0] ADDR_BOARD    = 8'h2c;
    localparam logic [7:0] ADDR_CAP_PTR  = 8'h34;
    localparam logic [7:0] ADDR_IRQ      = 8'h3c;
    localparam logic [7:0] ADDR_PM_CAP   = 8'h80;

    // ************************************************************
    // Fixed field values
    // ************************************************************
    localparam logic [7:0]  CLASS_PROG_IF   = 8'h02;
    localparam logic [7:0]  CLASS_SUB       = 8'h00;
    localparam logic [7:0]  CLASS_BASE      = 8'h07;
    localparam logic [7:0]  LATENCY_VALUE   = 8'h00;
    localparam logic [7:0]  LAYOUT_VALUE    = 8'h00;
    localparam logic [7:0]  IRQ_PIN_VALUE   = 8'h01;
    localparam logic [7:0]  PM_TAG_VALUE    = 8'h01;
    localparam logic [7:0]  PM_NEXT_VALUE   = 8'h8c;
    localparam logic [2:0]  PM_REV_VALUE    = 3'h3;
    localparam logic        PM_CLOCK_VALUE  = 1'b0;
    localparam logic        PM_AUX_VALUE    = 1'b1;
    localparam int          STATUS_CAP_BIT  = 20;

    // ************************************************************
    // Reset values
    // ************************************************************
    // Revision and board codes: arbitrary neutral values
    localparam logic [7:0]  RST_REVISION    = 8'h5a;
    localparam logic [15:0] RST_BOARD_VEND  = 16'h1357;
    localparam logic [15:0] RST_BOARD_PROD  = 16'h2468;
    localparam logic [7:0]  RST_CAP_PTR     = 8'h80;
    localparam logic [7:0]  RST_LINE_SIZE   = 8'h00;
    localparam logic [7:0]  RST_IRQ_ROUTE   = 8'h00;
    localparam logic [31:0] RST_IO_BASE     = 32'h0000_0001;
    localparam logic [31:0] RST_MEM_BASE    = 32'h0000_0000;
    localparam logic        RST_PM_DSI      = 1'b0;
    localparam logic [2:0]  RST_PM_AUX_CUR  = 3'h7;
    localparam logic        RST_PM_D1       = 1'b1;
    localparam logic        RST_PM_D2       = 1'b1;
    localparam logic [4:0]  RST_PM_EVENTS   = 5'h08;

    // ************************************************************
    // Loader field selects
    // ************************************************************
    typedef enum logic [2:0] {
        PCH_LD_REVISION = 3'h0,
        PCH_LD_VENDOR   = 3'h1,
        PCH_LD_PRODUCT  = 3'h2,
        PCH_LD_CAP_PTR  = 3'h3,
        PCH_LD_PM_CAPS  = 3'h4
    } pch_load_sel_t;

endpackage

// ==== hw/pch_config_regs.sv ====
// Configuration header register bank reached over APB.
// Assumes a default loader on pclk that holds load_busy high until done.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Byte-lane merge for the full-word read-write registers
// ************************************************************
module pch_lane_merge
#(
    parameter int LANES = 4
)
(
    input  wire logic [8*LANES-1:0] old_word,
    input  wire logic [8*LANES-1:0] new_word,
    input  wire logic [LANES-1:0]   lanes,
    output logic      [8*LANES-1:0] merged
);

    // A lane with its strobe low keeps the stored byte
    always_comb
    begin
        merged = old_word;
        for (int b = 0; b < LANES; b++)
        begin
            if (lanes[b])
            begin
                merged[8*b +: 8] = new_word[8*b +: 8];
            end
        end
    end

endmodule

module pch_config_regs
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        load_busy,
    input  wire logic        load_wr,
    input  wire logic [2:0]  load_sel,
    input  wire logic [15:0] load_data,
    output logic [31:0]      io_window_base,
    output logic [31:0]      mem_window_base,
    output logic [7:0]       irq_routing,
    output logic [7:0]       line_size_hint
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
        logic        slverr;
        logic [7:0]  revision;
        logic [15:0] board_vend;
        logic [15:0] board_prod;
        logic [7:0]  cap_ptr;
        logic        pm_dsi;
        logic [2:0]  pm_aux_cur;
        logic        pm_d1;
        logic        pm_d2;
        logic [4:0]  pm_events;
        logic [7:0]  line_size;
        logic [7:0]  irq_route;
        logic [31:0] io_base;
        logic [31:0] mem_base;
    } pch_state_t;

    pch_state_t state_q;
    pch_state_t state_d;

    logic        access;
    logic        commit;
    logic        hit;
    logic [31:0] rd_word;
    logic [31:0] io_merged;
    logic [31:0] mem_merged;

    // ************************************************************
    // Write data merged per byte lane
    // ************************************************************
    pch_lane_merge
    #(
        .LANES    (4)
    )
    io_merge_u
    (
        .old_word (state_q.io_base),
        .new_word (pwdata),
        .lanes    (pstrb),
        .merged   (io_merged)
    );

    pch_lane_merge
    #(
        .LANES    (4)
    )
    mem_merge_u
    (
        .old_word (state_q.mem_base),
        .new_word (pwdata),
        .lanes    (pstrb),
        .merged   (mem_merged)
    );

    // ************************************************************
    // Read decode
    // ************************************************************
    always_comb
    begin
        hit     = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            pch_pkg::ADDR_STATUS:
            begin
                rd_word[pch_pkg::STATUS_CAP_BIT] = 1'b1;
            end
            pch_pkg::ADDR_CLASS:
            begin
                rd_word = {pch_pkg::CLASS_BASE,
                           pch_pkg::CLASS_SUB,
                           pch_pkg::CLASS_PROG_IF,
                           state_q.revision};
            end
            pch_pkg::ADDR_MISC:
            begin
                rd_word = {8'h00,
                           pch_pkg::LAYOUT_VALUE,
                           pch_pkg::LATENCY_VALUE,
                           state_q.line_size};
            end
            pch_pkg::ADDR_IO_BASE:
            begin
                rd_word = state_q.io_base;
            end
            pch_pkg::ADDR_MEM_BASE:
            begin
                rd_word = state_q.mem_base;
            end
            pch_pkg::ADDR_BOARD:
            begin
                rd_word = {state_q.board_prod,
                           state_q.board_vend};
            end
            pch_pkg::ADDR_CAP_PTR:
            begin
                rd_word = {24'h00_0000, state_q.cap_ptr};
            end
            pch_pkg::ADDR_IRQ:
            begin
                rd_word = {16'h0000,
                           pch_pkg::IRQ_PIN_VALUE,
                           state_q.irq_route};
            end
            pch_pkg::ADDR_PM_CAP:
            begin
                rd_word = {state_q.pm_events,
                           state_q.pm_d2,
                           state_q.pm_d1,
                           state_q.pm_aux_cur,
                           state_q.pm_dsi,
                           pch_pkg::PM_AUX_VALUE,
                           pch_pkg::PM_CLOCK_VALUE,
                           pch_pkg::PM_REV_VALUE,
                           pch_pkg::PM_NEXT_VALUE,
                           pch_pkg::PM_TAG_VALUE};
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Bus handshake and register updates
    // ************************************************************
    assign access = psel && penable;
    assign commit = access && state_q.ready;

    always_comb
    begin
        state_d        = state_q;
        state_d.ready  = 1'b0;
        state_d.slverr = 1'b0;

        // No answer while defaults are still loading
        if (access && !state_q.ready && !load_busy)
        begin
            state_d.ready  = 1'b1;
            state_d.slverr = !hit;
            state_d.rdata  = pwrite ? 32'h0000_0000 : rd_word;
        end

        // Only read-write fields take bus writes; byte lanes respected
        if (commit && pwrite)
        begin
            unique case (paddr)
                pch_pkg::ADDR_MISC:
                begin
                    if (pstrb[0])
                    begin
                        state_d.line_size = pwdata[7:0];
                    end
                end
                pch_pkg::ADDR_IO_BASE:
                begin
                    state_d.io_base = io_merged;
                end
                pch_pkg::ADDR_MEM_BASE:
                begin
                    state_d.mem_base = mem_merged;
                end
                pch_pkg::ADDR_IRQ:
                begin
                    if (pstrb[0])
                    begin
                        state_d.irq_route = pwdata[7:0];
                    end
                end
                default:
                begin
                    state_d.ready = 1'b0;
                end
            endcase
        end

        // Loader replaces the replaceable defaults
        if (load_wr)
        begin
            unique case (load_sel)
                pch_pkg::PCH_LD_REVISION:
                begin
                    state_d.revision = load_data[7:0];
                end
                pch_pkg::PCH_LD_VENDOR:
                begin
                    state_d.board_vend = load_data;
                end
                pch_pkg::PCH_LD_PRODUCT:
                begin
                    state_d.board_prod = load_data;
                end
                pch_pkg::PCH_LD_CAP_PTR:
                begin
                    state_d.cap_ptr = load_data[7:0];
                end
                pch_pkg::PCH_LD_PM_CAPS:
                begin
                    // Image bits 15:5 map onto capability bits 31:21
                    state_d.pm_dsi     = load_data[5];
                    state_d.pm_aux_cur = load_data[8:6];
                    state_d.pm_d1      = load_data[9];
                    state_d.pm_d2      = load_data[10];
                    state_d.pm_events  = load_data[15:11];
                end
                default:
                begin
                    state_d.ready = state_d.ready;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q.ready      <= 1'b0;
            state_q.rdata      <= 32'h0000_0000;
            state_q.slverr     <= 1'b0;
            state_q.revision   <= pch_pkg::RST_REVISION;
            state_q.board_vend <= pch_pkg::RST_BOARD_VEND;
            state_q.board_prod <= pch_pkg::RST_BOARD_PROD;
            state_q.cap_ptr    <= pch_pkg::RST_CAP_PTR;
            state_q.pm_dsi     <= pch_pkg::RST_PM_DSI;
            state_q.pm_aux_cur <= pch_pkg::RST_PM_AUX_CUR;
            state_q.pm_d1      <= pch_pkg::RST_PM_D1;
            state_q.pm_d2      <= pch_pkg::RST_PM_D2;
            state_q.pm_events  <= pch_pkg::RST_PM_EVENTS;
            state_q.line_size  <= pch_pkg::RST_LINE_SIZE;
            state_q.irq_route  <= pch_pkg::RST_IRQ_ROUTE;
            state_q.io_base    <= pch_pkg::RST_IO_BASE;
            state_q.mem_base   <= pch_pkg::RST_MEM_BASE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign pready          = state_q.ready;
    assign prdata          = state_q.rdata;
    assign pslverr         = state_q.slverr;
    assign io_window_base  = state_q.io_base;
    assign mem_window_base = state_q.mem_base;
    assign irq_routing     = state_q.irq_route;
    assign line_size_hint  = state_q.line_size;

endmodule

`default_nettype wire

// ==== verif/pch_loader_model.sv ====
// Default loader model: replays a small load table after each reset.
// Drives the loader port of pch_config_regs on pclk.
`timescale 1ns/10ps
`default_nettype none
module pch_loader_model
#(
    parameter logic [15:0] LD_REV  = 16'h00a5,
    parameter logic [15:0] LD_VEND = 16'hc3e1,
    parameter logic [15:0] LD_PROD = 16'h4b7d,
    parameter logic [15:0] LD_CAP  = 16'h0090,
    parameter logic [15:0] LD_PM   = 16'h5aa0
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    output logic             load_busy,
    output logic             load_wr,
    output logic [2:0]       load_sel,
    output logic [15:0]      load_data
);
    logic [3:0] step_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            step_q    <= 4'h0;
            load_busy <= 1'b1;
            load_wr   <= 1'b0;
            load_sel  <= 3'h0;
            load_data <= 16'h0000;
        end
        else if (step_q != 4'h9)
        begin
            step_q    <= step_q + 4'h1;
            load_busy <= (step_q != 4'h8);
            load_wr   <= (step_q < 4'h5);
            load_sel  <= step_q[2:0];
            case (step_q[2:0])
                3'h0:    load_data <= LD_REV;
                3'h1:    load_data <= LD_VEND;
                3'h2:    load_data <= LD_PROD;
                3'h3:    load_data <= LD_CAP;
                default: load_data <= LD_PM;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verif/pch_regs_sva.sv ====
// Port checker for the configuration header bank.
// Bound to every pch_config_regs; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module pch_regs_sva
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        load_busy,
    input wire logic        load_wr,
    input wire logic [2:0]  load_sel,
    input wire logic [15:0] load_data,
    input wire logic [31:0] io_window_base,
    input wire logic [31:0] mem_window_base,
    input wire logic [7:0]  irq_routing,
    input wire logic [7:0]  line_size_hint
);
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = psel && penable && pready && pwrite;
    assign rd_ok = psel && penable && pready && !pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_BUSY_HOLD: assert property (load_busy |=> !pready)
        else $error("answer while loader busy");
    AST_ANSWER: assert property (psel && penable && !pready && !load_busy
        |=> pready) else $error("answer late");
    AST_CLASS: assert property (rd_ok && paddr == 8'h08 |->
        prdata[31:8] == 24'h070002) else $error("class code wrong");
    AST_MISC: assert property (rd_ok && paddr == 8'h0c |->
        prdata[31:8] == 24'h0) else $error("latency or layout wrong");
    AST_IRQ_PIN: assert property (rd_ok && paddr == 8'h3c |->
        prdata[31:8] == 24'h000001) else $error("irq pin wrong");
    AST_PM_FIXED: assert property (rd_ok && paddr == 8'h80 |->
        prdata[20:0] == 21'h138c01) else $error("power caps wrong");
    AST_STATUS: assert property (rd_ok && paddr == 8'h04 |->
        prdata[20]) else $error("capability list bit clear");
    AST_IO_HOLD: assert property (!(wr_ok && paddr == 8'h10)
        |=> $stable(io_window_base)) else $error("io base moved");
    AST_MEM_WR: assert property (wr_ok && paddr == 8'h14 && &pstrb
        |=> mem_window_base == $past(pwdata)) else $error("mem base");
    AST_LS_HOLD: assert property (!(wr_ok && paddr == 8'h0c)
        |=> $stable(line_size_hint)) else $error("line size moved");
    AST_IRQ_HOLD: assert property (!(wr_ok && paddr == 8'h3c)
        |=> $stable(irq_routing)) else $error("irq routing moved");
    cover property (rd_ok && paddr == 8'h80);
    cover property (wr_ok && pslverr);
    cover property (load_wr ##1 load_busy);
endmodule
bind pch_config_regs pch_regs_sva chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .load_busy(load_busy), .load_wr(load_wr),
    .load_sel(load_sel), .load_data(load_data),
    .io_window_base(io_window_base), .mem_window_base(mem_window_base),
    .irq_routing(irq_routing), .line_size_hint(line_size_hint));
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the configuration header bank.
// Drives APB itself; the loader model feeds the load port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
    failures++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module testbench;
    localparam logic [15:0] LV = 16'h00a5, LN = 16'hc3e1, LP = 16'h4b7d;
    localparam logic [15:0] LC = 16'h0090, LM = 16'h5aa0;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0] pstrb = 0;
    wire logic pready, pslverr, lbusy, lwr;
    wire logic [31:0] prdata, io_b, mem_b;
    wire logic [7:0] irq_r, ls_h;
    wire logic [2:0] lsel;
    wire logic [15:0] ldat;
    int failures = 0, num_checks = 0;
    logic [31:0] m_io = 1, m_mem = 0, rdat, d;
    logic [7:0] m_ls = 0, m_irq = 0, a;
    logic [3:0] s;
    logic rerr;
    logic [7:0] addrs[$] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h2c,
        8'h34, 8'h3c, 8'h80, 8'h18, 8'h82};
    always #25 pclk = ~pclk;
    pch_config_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .load_busy(lbusy), .load_wr(lwr), .load_sel(lsel),
        .load_data(ldat), .io_window_base(io_b), .mem_window_base(mem_b),
        .irq_routing(irq_r), .line_size_hint(ls_h));
    pch_loader_model #(.LD_REV(LV), .LD_VEND(LN), .LD_PROD(LP),
        .LD_CAP(LC), .LD_PM(LM)) ld_u (.pclk(pclk), .presetn(presetn),
        .load_busy(lbusy), .load_wr(lwr), .load_sel(lsel), .load_data(ldat));
    function automatic logic [32:0] expw(input logic [7:0] ad);
        case (ad)
            8'h04: expw = {1'b0, 32'h0010_0000};
            8'h08: expw = {1'b0, 24'h070002, LV[7:0]};
            8'h0c: expw = {1'b0, 24'h0, m_ls};
            8'h10: expw = {1'b0, m_io};
            8'h14: expw = {1'b0, m_mem};
            8'h2c: expw = {1'b0, LP, LN};
            8'h34: expw = {1'b0, 24'h0, LC[7:0]};
            8'h3c: expw = {1'b0, 16'h0001, m_irq};
            8'h80: expw = {1'b0, LM[15:5], 21'h138c01};
            default: expw = {1'b1, 32'h0};
        endcase
    endfunction
    task test_done;
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ad,
        input logic [31:0] dd, input logic [3:0] ss);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dd;
        pstrb <= ss;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 100);
        rdat = prdata;
        rerr = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            failures++;
            test_done();
        end
    endtask
    task automatic rd(input logic [7:0] ad);
        logic [32:0] e;
        e = expw(ad);
        apb(1'b0, ad, 32'h0, 4'h0);
        `CHK("rdata", e[31:0], rdat)
        `CHK("slverr", e[32], rerr)
    endtask
    task automatic wr_chk(input logic [7:0] ad, input logic [31:0] dd,
        input logic [3:0] ss);
        logic [32:0] e;
        e = expw(ad);
        apb(1'b1, ad, dd, ss);
        for (int i = 0; i < 4; i++)
            if (ss[i] && ad == 8'h10) m_io[8*i+:8] = dd[8*i+:8];
            else if (ss[i] && ad == 8'h14) m_mem[8*i+:8] = dd[8*i+:8];
        if (ss[0] && ad == 8'h0c) m_ls = dd[7:0];
        if (ss[0] && ad == 8'h3c) m_irq = dd[7:0];
        `CHK("wr_err", e[32], rerr)
        @(negedge pclk);
        `CHK("io_base", m_io, io_b)
        `CHK("mem_base", m_mem, mem_b)
        `CHK("line_size", m_ls, ls_h)
        `CHK("irq_route", m_irq, irq_r)
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        void'($urandom(11));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h08);
        foreach (addrs[i]) rd(addrs[i]);
        rd(8'h80);
        rd(8'h3c);
        repeat (60)
        begin
            a = addrs[$urandom % addrs.size()];
            d = $urandom;
            s = ($urandom % 2) ? 4'hf : 4'($urandom);
            wr_chk(a, d, s);
            rd(a);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m_io = 1;
        m_mem = 0;
        m_ls = 0;
        m_irq = 0;
        wr_chk(8'h04, 32'h0, 4'h0);
        foreach (addrs[i]) rd(addrs[i]);
        test_done();
    end
endmodule
`default_nettype wire
